// ---- flash_cmd_map.vh ----
// Constants for the security-register read and software reset logic
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// Command opcodes
`define OPC_SECREG_READ  8'h48
`define OPC_RESET_ARM    8'h66
`define OPC_RESET_DO     8'h99

// Address layout of a security register access
`define ADDR_BITS        24
`define ADDR_SEL_HI      15
`define ADDR_SEL_LO      12
`define SECREG_COUNT     3
`define DUMMY_BITS       8

// Recovery window after an accepted reset
`define CLK_PERIOD_NS    20
`define RST_TIME_NS      30000
`define RST_CYCLES       ((`RST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register byte offsets
`define REG_LOCK         8'h00
`define REG_VOLATILE     8'h04
`define REG_STATE        8'h08
`define REG_MEM_ADDR     8'h0c
`define REG_MEM_DATA     8'h10

// Fields of the volatile register
`define VOL_WEL_BIT      0
`define VOL_PAUSE_BIT    1
`define VOL_BUSY_BIT     2
`define VOL_WRAP_LO      4
`define VOL_WRAP_HI      6
`define VOL_PARAM_LO     8
`define VOL_PARAM_HI     15
`define VOL_STAT_LO      16
`define VOL_STAT_HI      23

// Reset values
`define VOL_RESET        32'h0000_0000
`define LOCK_RESET       3'h0

`endif

// ---- flash_secreg_read_and_soft_reset.v ----
// Security register read command, software reset pair and prefetch FIFO
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO with valid/ready on both sides
module byte_fifo #(
    parameter WIDTH  = 8,
    parameter DEPTH  = 16,
    parameter ADDR_W = 4
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             reset,
    input  wire             clear,
    // Filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0]  store [0:DEPTH-1]; // Word storage
    reg [ADDR_W-1:0] wr_ptr;            // Next slot to fill
    reg [ADDR_W-1:0] rd_ptr;            // Oldest slot
    reg [ADDR_W:0]   count;             // Words held
    wire             push;
    wire             pop;

    assign in_ready  = (count != DEPTH[ADDR_W:0]);
    assign out_valid = (count != {(ADDR_W+1){1'b0}});
    assign out_data  = store[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count upkeep
    always @(posedge clk_sys) begin
        if (reset || clear) begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            count  <= {(ADDR_W+1){1'b0}};
        end else begin
            if (push) begin
                store[wr_ptr] <= in_data;
                wr_ptr        <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // byte_fifo

////////////////////////////////////////////////////////////////////////////////
module flash_secreg_read_and_soft_reset #(
    parameter FIFO_DEPTH  = 16,
    parameter FIFO_ADDR_W = 4,
    parameter RST_CYCLES  = `RST_CYCLES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // Serial pins, sampled on clk_sys
    input  wire        spi_cs_n,
    input  wire        spi_clk,
    input  wire        serial_in_pin,
    output reg         serial_out,
    output reg         serial_out_en,
    // Register port
    input  wire [7:0]  bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output reg  [31:0] bus_rdata
);
    // Frame states
    localparam ST_OPC   = 3'd0;
    localparam ST_ADDR  = 3'd1;
    localparam ST_DUMMY = 3'd2;
    localparam ST_DATA  = 3'd3;
    localparam ST_SKIP  = 3'd4;

    reg  [7:0]  secreg [0:1023];   // Three registers, 256 bytes each, in four 256-byte slots
    reg  [2:0]  state;             // Frame state
    reg  [4:0]  bit_cnt;           // Bits taken in current field
    reg  [23:0] shift_in;          // Incoming bit shifter
    reg  [2:0]  out_idx;           // Bit position within output byte
    reg  [7:0]  out_shift;         // Byte being sent
    reg         clk_q;             // Previous serial clock level
    reg         fetch_on;          // Prefetch enabled
    reg  [1:0]  fetch_sel;         // Selected register
    reg  [7:0]  fetch_ptr;         // Next byte to prefetch
    reg         armed;             // Reset armed by 66h
    reg  [11:0] recov_cnt;         // Recovery cycles left
    reg  [2:0]  otp_lock_bits;     // Lock per register, set only
    reg  [31:0] vol_reg;           // Volatile settings
    reg  [9:0]  mem_addr;          // Software fill pointer
    reg         soft_reset;        // One-cycle reset action
    wire        clk_rise;
    wire        clk_fall;
    wire [7:0]  opcode;
    wire [23:0] addr_full;
    wire        addr_ok;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [7:0]  fifo_out_data;
    wire        fifo_pop;
    wire        fifo_clear;
    wire [1:0]  wr_sel;

    assign clk_rise   = spi_clk & ~clk_q;
    assign clk_fall   = ~spi_clk & clk_q;
    assign opcode     = {shift_in[6:0], serial_in_pin};
    assign addr_full  = {shift_in[22:0], serial_in_pin};
    // Register field in 1..3, bits 23:16 and 11:8 zero
    assign addr_ok    = (addr_full[23:16] == 8'h00) && (addr_full[11:8] == 4'h0) &&
                        (addr_full[`ADDR_SEL_HI:`ADDR_SEL_LO] != 4'h0) &&
                        (addr_full[`ADDR_SEL_HI:`ADDR_SEL_LO] <= 4'h3);
    assign fifo_pop   = (state == ST_DATA) && clk_fall && (out_idx == 3'd0) && !spi_cs_n;
    assign fifo_clear = spi_cs_n | soft_reset;
    assign wr_sel     = mem_addr[9:8];

    ////////////////////////////////////////////////////////////////////////////
    // Prefetch buffer between the register array and the output shifter
    byte_fifo #(
        .WIDTH  (8),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_ADDR_W)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clear     (fifo_clear),
        .in_valid  (fetch_on),
        .in_ready  (fifo_in_ready),
        .in_data   (secreg[{fetch_sel, fetch_ptr}]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command framing, decode and output shifting
    always @(posedge clk_sys) begin
        if (reset) begin
            state         <= ST_OPC;
            bit_cnt       <= 5'd0;
            shift_in      <= 24'h000000;
            out_idx       <= 3'd0;
            out_shift     <= 8'h00;
            clk_q         <= 1'b0;
            fetch_on      <= 1'b0;
            fetch_sel     <= 2'd0;
            fetch_ptr     <= 8'h00;
            armed         <= 1'b0;
            recov_cnt     <= 12'd0;
            soft_reset    <= 1'b0;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            clk_q      <= spi_clk;
            soft_reset <= 1'b0;
            // Recovery countdown
            if (recov_cnt != 12'd0) begin
                recov_cnt <= recov_cnt - 1'b1;
            end
            // Prefetch advance, wrapping inside the register
            if (fetch_on && fifo_in_ready) begin
                fetch_ptr <= fetch_ptr + 8'h01;
            end
            if (spi_cs_n || soft_reset) begin
                // Deselect ends the command and releases the output
                state         <= ST_OPC;
                bit_cnt       <= 5'd0;
                out_idx       <= 3'd0;
                fetch_on      <= 1'b0;
                serial_out_en <= 1'b0;
                serial_out    <= 1'b0;
            end else begin
                case (state)
                    ST_OPC: begin
                        if (clk_rise) begin
                            shift_in <= {shift_in[22:0], serial_in_pin};
                            bit_cnt  <= bit_cnt + 1'b1;
                            if (bit_cnt == 5'd7) begin
                                bit_cnt <= 5'd0;
                                if (recov_cnt != 12'd0) begin
                                    // Still reinitialising
                                    state <= ST_SKIP;
                                end else if (opcode == `OPC_RESET_DO && armed) begin
                                    armed      <= 1'b0;
                                    soft_reset <= 1'b1;
                                    recov_cnt  <= RST_CYCLES[11:0];
                                    state      <= ST_SKIP;
                                end else begin
                                    // Arm on 66h, anything else disarms
                                    armed <= (opcode == `OPC_RESET_ARM);
                                    if (opcode == `OPC_SECREG_READ) begin
                                        state <= ST_ADDR;
                                    end else begin
                                        state <= ST_SKIP;
                                    end
                                end
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (clk_rise) begin
                            shift_in <= {shift_in[22:0], serial_in_pin};
                            bit_cnt  <= bit_cnt + 1'b1;
                            if (bit_cnt == 5'd23) begin
                                bit_cnt <= 5'd0;
                                if (addr_ok) begin
                                    fetch_sel <= addr_full[13:12] - 2'd1;
                                    fetch_ptr <= addr_full[7:0];
                                    fetch_on  <= 1'b1;
                                    state     <= ST_DUMMY;
                                end else begin
                                    // Bad address: command ignored
                                    state <= ST_SKIP;
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        if (clk_rise) begin
                            bit_cnt <= bit_cnt + 1'b1;
                            if (bit_cnt == `DUMMY_BITS - 1) begin
                                bit_cnt <= 5'd0;
                                out_idx <= 3'd0;
                                state   <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (clk_fall) begin
                            serial_out_en <= 1'b1;
                            out_idx       <= out_idx + 1'b1;
                            if (out_idx == 3'd0) begin
                                // New byte, MSB first
                                out_shift  <= fifo_out_valid ? fifo_out_data : 8'hff;
                                serial_out <= fifo_out_valid ? fifo_out_data[7] : 1'b1;
                            end else begin
                                out_shift  <= {out_shift[6:0], 1'b0};
                                serial_out <= out_shift[6];
                            end
                        end
                    end
                    ST_SKIP: begin
                        // Rest of frame ignored
                        serial_out_en <= 1'b0;
                    end
                    default: begin
                        state <= ST_SKIP;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, lock bits, volatile settings and array fill
    always @(posedge clk_sys) begin
        if (reset) begin
            otp_lock_bits <= `LOCK_RESET;
            vol_reg       <= `VOL_RESET;
            mem_addr      <= 10'd0;
        end else begin
            if (soft_reset) begin
                // Abort work and drop volatile state
                vol_reg <= `VOL_RESET;
            end else if (bus_wr && bus_addr == `REG_VOLATILE) begin
                vol_reg <= bus_wdata & 32'h00ff_ff77;
            end
            if (bus_wr && bus_addr == `REG_LOCK) begin
                // Lock bits can only be set
                otp_lock_bits <= otp_lock_bits | bus_wdata[2:0];
            end
            if (bus_wr && bus_addr == `REG_MEM_ADDR) begin
                mem_addr <= bus_wdata[9:0];
            end
            if (bus_wr && bus_addr == `REG_MEM_DATA) begin
                // Programming a locked or absent register is ignored
                if (wr_sel != 2'd3 && !otp_lock_bits[wr_sel]) begin
                    secreg[mem_addr] <= bus_wdata[7:0];
                end
                mem_addr <= mem_addr + 10'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads, data in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (reset) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (bus_addr)
                `REG_LOCK:     bus_rdata <= {29'd0, otp_lock_bits};
                `REG_VOLATILE: bus_rdata <= vol_reg;
                `REG_STATE:    bus_rdata <= {12'd0, recov_cnt, 2'd0, state,
                                             fetch_on, (recov_cnt != 12'd0), armed};
                `REG_MEM_ADDR: bus_rdata <= {22'd0, mem_addr};
                `REG_MEM_DATA: bus_rdata <= {24'd0, secreg[mem_addr]};
                default:       bus_rdata <= 32'h0000_0000;
            endcase
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end
endmodule // flash_secreg_read_and_soft_reset
`default_nettype wire

// ---- flash_secreg_props.sv ----
// Pin-level assertions for the security register read and soft reset logic
`timescale 1ns/1ns
`default_nettype none
module flash_secreg_props #(
    parameter FIFO_DEPTH  = 16,
    parameter FIFO_ADDR_W = 4,
    parameter RST_CYCLES  = 1500
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // Serial pins
    input wire logic        spi_cs_n,
    input wire logic        spi_clk,
    input wire logic        serial_in_pin,
    input wire logic        serial_out,
    input wire logic        serial_out_en,
    // Register port
    input wire logic [7:0]  bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata
);
    logic        clk_q; // Serial clock one sample back
    logic [5:0]  rises; // Rising edges in this frame, saturating
    logic [31:0] hdr;   // Opcode and address as shifted in
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the frame header, cleared while select is high
    always_ff @(posedge clk_sys) begin
        if (reset || spi_cs_n) begin
            rises <= 6'h00;
            hdr   <= 32'h0;
        end else if (spi_clk && !clk_q) begin
            if (rises != 6'h3f) rises <= rises + 6'h01;
            if (rises < 6'h20) hdr <= {hdr[30:0], serial_in_pin};
        end
        clk_q <= spi_clk;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data outside its answer cycle");
    out_fall_a: assert property (serial_out_en && $past(serial_out_en) && $changed(serial_out)
        |-> !spi_clk && !$past(spi_clk)) else $error("output bit moved away from a falling edge");
    en_cs_a: assert property (spi_cs_n [*3] |-> !serial_out_en)
        else $error("output still driven after deselect");
    en_count_a: assert property (!spi_cs_n && !$past(spi_cs_n) && serial_out_en |-> rises >= 6'h28)
        else $error("output before opcode, address and dummies");
    en_opcode_a: assert property (!spi_cs_n && !$past(spi_cs_n) && serial_out_en |-> hdr[31:24] == 8'h48)
        else $error("output for a foreign opcode");
    en_rise_a: assert property ($rose(serial_out_en) |-> !spi_clk && rises == 6'h28)
        else $error("output not started on the first fall after dummies");
    en_addr_a: assert property (!spi_cs_n && !$past(spi_cs_n) && serial_out_en |-> hdr[23:16] == 8'h00
        && hdr[11:8] == 4'h0 && hdr[15:12] inside {4'h1, 4'h2, 4'h3}) else $error("output for a bad address");
    en_hold_a: assert property (serial_out_en && !spi_cs_n |=> serial_out_en)
        else $error("stream broke while selected");
    // Main scenarios seen
    cover property ($rose(serial_out_en));
    cover property ($fell(serial_out_en));
    cover property (bus_rd ##1 bus_rdata != 32'h0);
endmodule // flash_secreg_props

bind flash_secreg_read_and_soft_reset flash_secreg_props #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_ADDR_W(FIFO_ADDR_W),
    .RST_CYCLES(RST_CYCLES)) props (.clk_sys(clk_sys), .reset(reset), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
    .serial_in_pin(serial_in_pin), .serial_out(serial_out), .serial_out_en(serial_out_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
`default_nettype wire

// ---- spi_host_model.sv ----
// Serial host model that frames commands toward the flash logic
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // Clock
    input  wire logic clk_sys,
    // Serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_en,
    // Output was driven in this frame
    output logic      seen_en
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        seen_en = 1'b0;
    end
    // Note any driven output
    always @(posedge clk_sys) if (miso_en === 1'b1) seen_en <= 1'b1;
    // Half serial period, four system cycles
    task automatic half();
        repeat (4) @(posedge clk_sys);
    endtask
    // Select low, then n bits MSB first, each set while the clock is low
    task automatic send(input logic [39:0] v, input int n);
        cs_n <= 1'b0;
        seen_en <= 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= v[i];
            half();
            sclk <= 1'b1;
            half();
        end
    endtask
    // One byte, MSB first, sampled on the rising edge
    task automatic recv(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'b0;
            half();
            b[i] = miso;
            sclk <= 1'b1;
            half();
        end
    endtask
    // Clock parked low, select released, data line no longer meaningful
    task automatic finish();
        sclk <= 1'b0;
        half();
        cs_n <= 1'b1;
        mosi <= ~mosi;
        half();
        half();
    endtask
endmodule // spi_host_model
`default_nettype wire

// ---- test_flash_secreg_read_and_soft_reset.sv ----
// Self-checking bench for the security register read and soft reset logic
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_map.vh"
module test_flash_secreg_read_and_soft_reset;
    logic        clk_sys, reset, spi_cs_n, spi_clk, serial_in_pin, serial_out, serial_out_en, seen_en;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic        bus_wr, bus_rd;
    int          bad_count, cmp_count;
    flash_secreg_read_and_soft_reset #(.RST_CYCLES(400)) DUT (.clk_sys(clk_sys), .reset(reset),
        .spi_cs_n(spi_cs_n), .spi_clk(spi_clk), .serial_in_pin(serial_in_pin), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    spi_host_model host (.clk_sys(clk_sys), .cs_n(spi_cs_n), .sclk(spi_clk), .mosi(serial_in_pin),
        .miso(serial_out), .miso_en(serial_out_en), .seen_en(seen_en));
    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles and comparison
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        // Let one edge pass so the next call never reassigns the strobe in this step
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        // Answer stands in the cycle after the strobe; take it at that cycle's closing edge
        @(posedge clk_sys);
        d = bus_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // Two bytes stored from a {register, offset} place
    task automatic load(input logic [9:0] a, input logic [7:0] d0, input logic [7:0] d1);
        wr(`REG_MEM_ADDR, {22'h0, a});
        wr(`REG_MEM_DATA, {24'h0, d0});
        wr(`REG_MEM_DATA, {24'h0, d1});
    endtask
    // One read frame; n bytes expected from exp, top byte first
    task automatic t_read(input logic [23:0] a, input logic [31:0] exp, input int n);
        logic [7:0] b;
        host.send({`OPC_SECREG_READ, a, 8'h00}, 40);
        for (int i = n - 1; i >= 0; i--) begin
            host.recv(b);
            chk({24'h0, b}, {24'h0, exp[i*8 +: 8]});
        end
        host.finish();
        chk({31'h0, seen_en}, {31'h0, n != 0});
    endtask
    // A short command frame
    task automatic cmd(input logic [7:0] op);
        host.send({32'h0, op}, 8);
        host.finish();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped place, writable mask
    task automatic t_regs();
        wr(8'h20, 32'hffff_ffff);
        chk_rd(`REG_LOCK, 32'h0);
        chk_rd(`REG_VOLATILE, 32'h0);
        chk_rd(`REG_STATE, 32'h0);
        chk_rd(8'h20, 32'h0);
        wr(`REG_VOLATILE, 32'hffff_ffff);
        chk_rd(`REG_VOLATILE, 32'h00ff_ff77);
    endtask
    // Streaming across the wrap, bad addresses, locked register
    task automatic t_stream();
        logic [23:0] bad [4] = '{24'h000010, 24'h004010, 24'h011010, 24'h001110};
        load(10'h0fe, 8'ha5, 8'h5a);
        load(10'h000, 8'hc3, 8'h3c);
        load(10'h210, 8'h77, 8'h88);
        t_read(24'h0010fe, 32'ha55a_c33c, 4);
        t_read(24'h003010, 32'h0000_7788, 2);
        foreach (bad[i]) t_read(bad[i], 32'h0, 0);
        wr(`REG_LOCK, 32'h1);
        load(10'h0fe, 8'h11, 8'h22);
        wr(`REG_MEM_ADDR, 32'h0fe);
        chk_rd(`REG_MEM_DATA, 32'ha5);
        chk_rd(`REG_LOCK, 32'h1);
    endtask
    // Arm, disarm, reset and the recovery window
    task automatic t_reset();
        logic [31:0] d;
        int n;
        wr(`REG_VOLATILE, 32'h00ff_ff71);
        chk_rd(`REG_VOLATILE, 32'h00ff_ff71);
        cmd(`OPC_RESET_ARM);
        chk_rd(`REG_STATE, 32'h1);
        cmd(8'h05);
        chk_rd(`REG_STATE, 32'h0);
        cmd(`OPC_RESET_DO);
        chk_rd(`REG_VOLATILE, 32'h00ff_ff71);
        cmd(`OPC_RESET_ARM);
        cmd(`OPC_RESET_DO);
        rd(`REG_STATE, d);
        chk({31'h0, d[1]}, 32'h1);
        chk_rd(`REG_VOLATILE, 32'h0);
        wr(`REG_VOLATILE, 32'h1);
        cmd(`OPC_RESET_ARM);
        cmd(`OPC_RESET_DO);
        n = 0;
        do begin
            rd(`REG_STATE, d);
            n++;
        end while (d[1] !== 1'b0 && n < 1000);
        chk(d, 32'h0);
        chk_rd(`REG_VOLATILE, 32'h1);
        chk_rd(`REG_LOCK, 32'h1);
    endtask
    // Verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog, main sequence
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        reset = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_stream();
        t_reset();
        stop_test();
    end
endmodule // test_flash_secreg_read_and_soft_reset
`default_nettype wire
